/* eepc_cfg.svh */
// Constants for the serial EEPROM command logic
`ifndef EEPC_CFG_SVH
`define EEPC_CFG_SVH
`define EEPC_OP_LATCH_SET 8'h06
`define EEPC_OP_LATCH_CLR 8'h04
`define EEPC_OP_STAT_RD 8'h05
`define EEPC_OP_STAT_WR 8'h01
`define EEPC_OP_ARR_RD 8'h03
`define EEPC_OP_ARR_WR 8'h02
`define EEPC_OP_MASK 8'hf7
`define EEPC_SR_BUSY 0
`define EEPC_SR_WEL 1
`define EEPC_SR_BP_LO 2
`define EEPC_SR_BP_HI 3
`define EEPC_SR_PPE 7
`define EEPC_SR_BUSY_VAL 8'hff
`define EEPC_PAGE_BYTES 32
`define EEPC_WRITE_CYCLE_US 5
`define EEPC_CLK_MHZ 40
`endif

/* eepc_pkg.sv */
// Types for the serial EEPROM command logic
package eepc_pkg;
    typedef enum logic [2:0] {
        EEPC_OPCODE = 3'b000,
        EEPC_ADDR = 3'b001,
        EEPC_RDATA = 3'b010,
        EEPC_WDATA = 3'b011,
        EEPC_SDATA = 3'b100,
        EEPC_SOUT = 3'b101,
        EEPC_IGNORE = 3'b110
    } eepc_state_e;
    typedef struct packed {
        logic sel_n;
        logic sclk;
        logic sdin;
        logic protect_n;
        logic pause_n;
    } eepc_pins_s;
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] data;
    } eepc_word_s;
endpackage : eepc_pkg

/* eepc_core.sv */
// Serial EEPROM command logic with page buffer and array
`include "eepc_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Page buffer FIFO
// ------------------------------------------------------------
// Plain pointer FIFO; one spare pointer bit tells full from empty
module eepc_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 16
) (
    // Clock and clear
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic flush,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr;
    logic [AW:0] rd_ptr;
    logic [AW:0] fill;
    assign fill = wr_ptr - rd_ptr;
    assign in_ready = (fill != (AW+1)'(DEPTH));
    assign out_valid = (fill != '0);
    assign out_data = mem[rd_ptr[AW-1:0]];
    // Storage is written only when a slot is free
    always_ff @(posedge ref_clk) begin
        if (in_valid && in_ready) begin
            mem[wr_ptr[AW-1:0]] <= in_data;
        end
    end
    // Pointers; flush drops everything queued
    always_ff @(posedge ref_clk) begin
        if (reset || flush) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (in_valid && in_ready) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (out_valid && out_ready) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
        end
    end
endmodule : eepc_fifo

module eepc_core #(
    parameter int ADDR_BITS = 10,
    parameter int FIFO_DEPTH = 16,
    parameter int WRITE_CYCLES = `EEPC_WRITE_CYCLE_US * `EEPC_CLK_MHZ
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // Serial pins from the master
    input wire eepc_pkg::eepc_pins_s pins,
    // Serial output, tristate split (enable low drives)
    output logic sdout_o,
    output logic sdout_oe_n,
    // Status
    output logic busy
);
    import eepc_pkg::*;
    localparam int DEPTH = 1 << ADDR_BITS;
    localparam int CW = $clog2(WRITE_CYCLES + 1);

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    eepc_pins_s p_meta;
    eepc_pins_s p_sync;
    eepc_pins_s p_last;
    // Two flops per pin before anything looks at them
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            p_meta <= '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1};
            p_sync <= '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1};
            p_last <= '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1};
        end else begin
            p_meta <= pins;
            p_sync <= p_meta;
            p_last <= p_sync;
        end
    end
    logic sel_fall;
    logic sel_rise;
    logic sck_rise;
    logic sck_fall;
    logic selected;
    logic paused;
    assign sel_fall = p_last.sel_n && !p_sync.sel_n;
    assign sel_rise = !p_last.sel_n && p_sync.sel_n;
    assign selected = !p_sync.sel_n;
    assign sck_rise = selected && !paused && !p_last.sclk && p_sync.sclk;
    assign sck_fall = selected && !paused && p_last.sclk && !p_sync.sclk;

    // Pause follows the pin only while the serial clock is low; deselect clears it
    always_ff @(posedge ref_clk) begin
        if (reset || !selected) begin
            paused <= 1'b0;
        end else if (!p_sync.sclk) begin
            paused <= !p_sync.pause_n;
        end
    end

    // ------------------------------------------------------------
    // Array, status bits and write cycle
    // ------------------------------------------------------------
    logic [7:0] array_mem [DEPTH];
    logic wel;
    logic [1:0] bp;
    logic ppe;
    logic [CW-1:0] wc_count;
    logic hw_prot;
    logic [7:0] status_val;
    assign busy = (wc_count != '0);
    assign hw_prot = !p_sync.protect_n && ppe;
    // Busy forces all ones; idle shows unused bits as zero
    assign status_val = busy ? `EEPC_SR_BUSY_VAL
                             : {ppe, 3'b000, bp, wel, 1'b0};

    // Protected region lower bound per level, from the array size
    function automatic logic is_protected(input logic [ADDR_BITS-1:0] a,
                                          input logic [1:0] lvl);
        unique case (lvl)
            2'b00: is_protected = 1'b0;
            2'b01: is_protected = (a[ADDR_BITS-1:ADDR_BITS-2] == 2'b11);
            2'b10: is_protected = a[ADDR_BITS-1];
            2'b11: is_protected = 1'b1;
        endcase
    endfunction : is_protected

    // ------------------------------------------------------------
    // Serial engine
    // ------------------------------------------------------------
    eepc_state_e state;
    logic [7:0] shreg;
    logic [2:0] bitcnt;
    logic [3:0] addr_cnt;
    logic [15:0] addr;
    logic [7:0] opcode;
    logic byte_done;
    logic on_boundary;
    logic got_byte;
    logic sr_pending;
    logic [7:0] sr_new;
    logic wr_ok;
    logic start_array;
    logic start_status;
    logic [7:0] op_now;
    logic latch_cmd_set;
    logic latch_cmd_clr;
    assign op_now = {shreg[6:0], p_sync.sdin} & `EEPC_OP_MASK;
    assign byte_done = sck_rise && (bitcnt == 3'd7);
    // got_byte counts only bytes that passed the protection check, so a
    // frame whose bytes were all refused starts no cycle
    assign start_array = sel_rise && (state == EEPC_WDATA) && on_boundary
                         && got_byte;
    // Pin protection is checked again here; the abort below can miss the
    // very cycle in which select rises
    assign start_status = sel_rise && sr_pending && on_boundary && !hw_prot;
    assign latch_cmd_set = byte_done && state == EEPC_OPCODE && !busy
                           && op_now == `EEPC_OP_LATCH_SET;
    assign latch_cmd_clr = byte_done && state == EEPC_OPCODE && !busy
                           && op_now == `EEPC_OP_LATCH_CLR;

    // Page buffer: bytes queue here until select rises, then program
    eepc_word_s fifo_in;
    eepc_word_s fifo_out;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic draining;
    logic push;
    // A full buffer drops further bytes; data keeps all eight bits
    assign push = byte_done && state == EEPC_WDATA && wr_ok && fifo_in_ready;
    assign fifo_in = '{addr, {shreg[6:0], p_sync.sdin}};
    // Never flush while draining: a quick new frame would lose queued bytes
    eepc_fifo #(.WIDTH(24), .DEPTH(FIFO_DEPTH)) u_fifo (
        .ref_clk(ref_clk),
        .reset(reset),
        .flush(!draining && (sel_fall || (sel_rise && !start_array))),
        .in_valid(push),
        .in_ready(fifo_in_ready),
        .in_data(fifo_in),
        .out_valid(fifo_out_valid),
        .out_ready(draining),
        .out_data(fifo_out)
    );

    // Bit counter and shift register, MSB first
    always_ff @(posedge ref_clk) begin
        if (reset || sel_fall) begin
            bitcnt <= '0;
            shreg <= '0;
        end else if (sck_rise) begin
            bitcnt <= bitcnt + 3'd1;
            shreg <= {shreg[6:0], p_sync.sdin};
        end
    end
    assign on_boundary = (bitcnt == 3'd0);

    // Command state machine
    always_ff @(posedge ref_clk) begin
        if (reset || sel_fall) begin
            state <= EEPC_OPCODE;
            addr_cnt <= '0;
            got_byte <= 1'b0;
            sr_pending <= 1'b0;
            opcode <= '0;
        end else if (!selected) begin
            state <= EEPC_IGNORE;
            sr_pending <= 1'b0;
        end else if (byte_done) begin
            unique case (state)
                EEPC_OPCODE: begin
                    opcode <= op_now;
                    if (busy && op_now != `EEPC_OP_STAT_RD) begin
                        state <= EEPC_IGNORE;
                    end else if (op_now == `EEPC_OP_STAT_RD) begin
                        state <= EEPC_SOUT;
                    end else if (op_now == `EEPC_OP_ARR_RD) begin
                        state <= EEPC_ADDR;
                    end else if (op_now == `EEPC_OP_ARR_WR && wel) begin
                        state <= EEPC_ADDR;
                    end else if (op_now == `EEPC_OP_STAT_WR) begin
                        state <= EEPC_SDATA;
                    end else begin
                        state <= EEPC_IGNORE;
                    end
                end
                EEPC_ADDR: begin
                    addr_cnt <= addr_cnt + 4'd1;
                    if (addr_cnt == 4'd1) begin
                        state <= (opcode == `EEPC_OP_ARR_RD) ? EEPC_RDATA : EEPC_WDATA;
                    end
                end
                EEPC_WDATA: begin
                    if (wr_ok) begin
                        got_byte <= 1'b1;
                    end
                end
                EEPC_SDATA: begin
                    // Latch and hardware protection gate the status write
                    sr_pending <= wel && !hw_prot;
                    sr_new <= {shreg[6:0], p_sync.sdin};
                    state <= EEPC_IGNORE;
                end
                default: state <= state;
            endcase
        end else if (sr_pending && hw_prot) begin
            sr_pending <= 1'b0;
        end
    end

    // Address register: 16 bits in, then the read or page counter
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            addr <= '0;
        end else if (byte_done && state == EEPC_ADDR) begin
            addr <= {addr[7:0], op_now | {shreg[6:0], p_sync.sdin}};
        end else if (byte_done && state == EEPC_WDATA) begin
            addr <= {addr[15:5], addr[4:0] + 5'd1};
        end else if (byte_done && state == EEPC_RDATA) begin
            // Wrap at the array top; unused upper bits read back as zero
            addr <= 16'(ADDR_BITS'(addr + 16'd1));
        end
    end
    // Array target must be outside the guarded blocks
    assign wr_ok = !is_protected(addr[ADDR_BITS-1:0], bp);

    // Output shifter: loaded on the byte edge, shifted on falling clock
    logic [7:0] out_sh;
    logic out_en;
    always_ff @(posedge ref_clk) begin
        if (reset || !selected) begin
            out_sh <= '0;
            out_en <= 1'b0;
        end else if (byte_done && (state == EEPC_RDATA || state == EEPC_SOUT
                     || (state == EEPC_ADDR && addr_cnt == 4'd1))) begin
            out_en <= 1'b1;
            out_sh <= (state == EEPC_SOUT || (state == EEPC_OPCODE)) ? status_val
                      : array_mem[(state == EEPC_ADDR) ? ADDR_BITS'({addr[7:0], 
                        op_now | {shreg[6:0], p_sync.sdin}}) : ADDR_BITS'(addr + 1'b1)];
        end else if (byte_done && state == EEPC_OPCODE
                     && op_now == `EEPC_OP_STAT_RD) begin
            out_en <= 1'b1;
            out_sh <= status_val;
        end else if (sck_fall && out_en && !on_boundary) begin
            out_sh <= {out_sh[6:0], 1'b0};
        end
    end
    // Data pin driven after the address of any array read or write and during status reads, and not while paused
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            sdout_o <= 1'b0;
            sdout_oe_n <= 1'b1;
        end else begin
            sdout_o <= out_sh[7];
            sdout_oe_n <= !(out_en && selected && !paused);
        end
    end

    // Latch, protect bits and write cycle timer
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            wel <= 1'b0;
            bp <= 2'b00;
            ppe <= 1'b0;
            wc_count <= '0;
            draining <= 1'b0;
        end else begin
            if (latch_cmd_set) begin
                wel <= 1'b1;
            end else if (latch_cmd_clr) begin
                wel <= 1'b0;
            end
            if (start_status) begin
                bp <= sr_new[`EEPC_SR_BP_HI:`EEPC_SR_BP_LO];
                // Enable may not drop while the pin holds protection
                ppe <= sr_new[`EEPC_SR_PPE] | hw_prot;
                wc_count <= CW'(WRITE_CYCLES);
            end else if (start_array) begin
                draining <= 1'b1;
                wc_count <= CW'(WRITE_CYCLES);
            end else if (busy) begin
                if (!fifo_out_valid) begin
                    draining <= 1'b0;
                end
                if (wc_count == CW'(1)) begin
                    wel <= 1'b0;
                end
                wc_count <= wc_count - CW'(1);
            end
        end
    end
    // Program queued bytes into the array during the cycle
    always_ff @(posedge ref_clk) begin
        if (draining && fifo_out_valid) begin
            array_mem[fifo_out.addr[ADDR_BITS-1:0]] <= fifo_out.data;
        end
    end
endmodule : eepc_core
`default_nettype wire

/* eepc_core_sva.sv */
// Port-level assertions for the serial EEPROM command logic
`timescale 1ns/1ps
`default_nettype none
module eepc_core_sva #(
    parameter int WRITE_CYCLES = 200
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // Serial pins and device outputs
    input wire eepc_pkg::eepc_pins_s pins,
    input wire logic sdout_o,
    input wire logic sdout_oe_n,
    input wire logic busy
);
    import eepc_pkg::*;
    // ----------------------------------------
    // Write cycle length counter
    // ----------------------------------------
    logic [15:0] blen;
    // Cleared whenever busy drops, so a stuck busy shows as an overrun
    always_ff @(posedge ref_clk) begin
        if (reset || !busy) begin
            blen <= 16'h0000;
        end else begin
            blen <= blen + 16'h0001;
        end
    end
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (reset);
    // ----------------------------------------
    // Assertions and covers
    // ----------------------------------------
    a_idle_out_off: assert property (pins.sel_n [*6] |-> sdout_oe_n)
        else $error("output driven while deselected");
    a_busy_length: assert property ($fell(busy) |-> int'(blen) == WRITE_CYCLES)
        else $error("write cycle length wrong");
    a_busy_bound: assert property (busy |-> int'(blen) < WRITE_CYCLES)
        else $error("write cycle overran");
    a_busy_after_sel: assert property ($rose(busy) |-> $past(pins.sel_n, 2) && $past(pins.sel_n, 3))
        else $error("write cycle began while selected");
    a_pause_out_off: assert property (!pins.pause_n [*6] |-> sdout_oe_n)
        else $error("output driven while paused");
    a_out_holds: assert property ($rose(pins.sclk) && !sdout_oe_n |=> $stable(sdout_o) [*3])
        else $error("output bit changed while clock high");
    a_busy_gap: assert property ($fell(busy) |-> !busy [*8])
        else $error("write cycle restarted at once");
    a_reset_quiet: assert property (disable iff (1'b0) reset |=> !busy && sdout_oe_n)
        else $error("outputs active after reset");
    c_write_cycle: cover property ($rose(busy));
    c_read_drive: cover property ($fell(sdout_oe_n));
    c_paused: cover property ($fell(pins.pause_n));
endmodule : eepc_core_sva
bind eepc_core eepc_core_sva #(.WRITE_CYCLES(WRITE_CYCLES)) sva_u (.ref_clk(ref_clk),
    .reset(reset), .pins(pins), .sdout_o(sdout_o), .sdout_oe_n(sdout_oe_n), .busy(busy));
`default_nettype wire

/* eepc_host_model.sv */
// Behavioural serial master driving the EEPROM command logic pins
`timescale 1ns/1ps
`default_nettype none
module eepc_host_model (
    // Clock
    input wire logic ref_clk,
    // Device outputs
    input wire logic sdout_o,
    input wire logic sdout_oe_n,
    // Serial pins to the device
    output var eepc_pkg::eepc_pins_s pins
);
    import eepc_pkg::*;
    // ----------------------------------------
    // Line level and frame tasks
    // ----------------------------------------
    wire logic sdo;
    // No pull on the data line, so an idle output reads as floating
    assign sdo = sdout_oe_n ? 1'bz : sdout_o;
    initial begin
        pins = '{sel_n: 1'b1, sclk: 1'b0, sdin: 1'b0, protect_n: 1'b1, pause_n: 1'b1};
    end
    task automatic begin_frame();
        @(negedge ref_clk);
        pins.sel_n <= 1'b0;
        repeat (4) @(negedge ref_clk);
    endtask : begin_frame
    // Half period of four clocks gives the 200 ns link clock; n below 8
    // sends only the leading bits, to cut a frame off a byte boundary
    task automatic xfer(input logic [7:0] tx, output logic [7:0] got, input int n = 8);
        for (int i = 7; i > 7 - n; i--) begin
            pins.sdin <= tx[i];
            repeat (4) @(negedge ref_clk);
            pins.sclk <= 1'b1;
            got[i] = sdo;
            repeat (4) @(negedge ref_clk);
            pins.sclk <= 1'b0;
        end
    endtask : xfer
    // Select rises in the clock low time; data line then shows junk
    task automatic end_frame();
        repeat (4) @(negedge ref_clk);
        pins.sel_n <= 1'b1;
        pins.sdin <= ~pins.sdin;
        repeat (8) @(negedge ref_clk);
    endtask : end_frame
    // Let the clock-low level settle before pausing, as the pin requires
    task automatic pause();
        repeat (2) @(negedge ref_clk);
        pins.pause_n <= 1'b0;
        repeat (10) @(negedge ref_clk);
        pins.pause_n <= 1'b1;
        repeat (4) @(negedge ref_clk);
    endtask : pause
    task automatic set_protect(input logic lvl);
        pins.protect_n <= lvl;
        repeat (4) @(negedge ref_clk);
    endtask : set_protect
endmodule : eepc_host_model
`default_nettype wire

/* test_spi_eeprom_command_logic.sv */
// Self-checking bench for the serial EEPROM command logic
`timescale 1ns/1ps
`default_nettype none
module test_spi_eeprom_command_logic;
    import eepc_pkg::*;
    // ----------------------------------------
    // Clock, reset and instances
    // ----------------------------------------
    logic ref_clk;
    logic reset;
    wire eepc_pins_s pins;
    wire logic sdout_o;
    wire logic sdout_oe_n;
    wire logic busy;
    logic [7:0] rx;
    int fails;
    int checks_done;
    // Defaults give the smaller array and the 16-byte page buffer
    eepc_core dut_u (.ref_clk(ref_clk), .reset(reset), .pins(pins), .sdout_o(sdout_o),
        .sdout_oe_n(sdout_oe_n), .busy(busy));
    eepc_host_model host_u (.ref_clk(ref_clk), .sdout_o(sdout_o), .sdout_oe_n(sdout_oe_n),
        .pins(pins));
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic check8(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t got %h want %h", $time, got, exp);
        end
    endtask : check8
    task automatic cmd(input logic [7:0] op);
        host_u.begin_frame();
        host_u.xfer(op, rx);
        host_u.end_frame();
    endtask : cmd
    // Status read with a pause between opcode and data
    task automatic status(input logic [7:0] exp);
        host_u.begin_frame();
        host_u.xfer(8'h05, rx);
        host_u.pause();
        host_u.xfer(8'h00, rx);
        host_u.end_frame();
        check8(rx, exp);
    endtask : status
    task automatic wr(input logic [7:0] op, input logic [15:0] a, input logic [7:0] d0,
            input logic [7:0] d1, input int n);
        host_u.begin_frame();
        host_u.xfer(op, rx);
        if (op == 8'h02) begin
            host_u.xfer(a[15:8], rx);
            host_u.xfer(a[7:0], rx);
        end
        host_u.xfer(d0, rx);
        if (n > 1) begin
            host_u.xfer(d1, rx);
        end
        host_u.end_frame();
    endtask : wr
    // Checks busy, then waits a bounded time for the cycle to end
    task automatic settle(input logic exp_busy);
        repeat (8) @(negedge ref_clk);
        check8({7'h00, busy}, {7'h00, exp_busy});
        for (int i = 0; i < 1000 && busy !== 1'b0; i++) @(negedge ref_clk);
        // A cycle that never ends counts as a mismatch here
        check8({7'h00, busy}, 8'h00);
    endtask : settle
    task automatic give_verdict();
        $display("checks_done=%0d fails=%0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : give_verdict
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_power();
        check8({7'h00, sdout_oe_n}, 8'h01);
        status(8'h00);
        wr(8'h02, 16'h0000, 8'h5a, 8'h00, 1);
        settle(1'b0);
        host_u.begin_frame();
        host_u.xfer(8'h07, rx);
        host_u.xfer(8'h00, rx);
        host_u.end_frame();
        check8(rx, 8'hzz);
    endtask : t_power
    task automatic t_latch();
        logic [7:0] ops [4] = '{8'h06, 8'h0c, 8'h0e, 8'h04};
        for (int i = 0; i < 4; i++) begin
            cmd(ops[i]);
            status((ops[i][2:0] == 3'b110) ? 8'h02 : 8'h00);
        end
        host_u.set_protect(1'b0);
        cmd(8'h06);
        cmd(8'h04);
        wr(8'h02, 16'h0000, 8'h5a, 8'h00, 1);
        settle(1'b0);
        host_u.set_protect(1'b1);
    endtask : t_latch
    task automatic t_page();
        cmd(8'h06);
        wr(8'h02, 16'h001f, 8'ha5, 8'h3c, 2);
        status(8'hff);
        settle(1'b1);
        status(8'h00);
        cmd(8'h06);
        wr(8'h02, 16'h03ff, 8'hc3, 8'h00, 1);
        settle(1'b1);
        host_u.begin_frame();
        host_u.xfer(8'h0b, rx);
        host_u.xfer(8'hfb, rx);
        host_u.xfer(8'hff, rx);
        host_u.xfer(8'h00, rx);
        check8(rx, 8'hc3);
        host_u.xfer(8'h00, rx);
        check8(rx, 8'h3c);
        host_u.end_frame();
    endtask : t_page
    task automatic t_protect();
        cmd(8'h06);
        wr(8'h09, 16'h0000, 8'h84, 8'h00, 1);
        settle(1'b1);
        status(8'h84);
        cmd(8'h06);
        wr(8'h02, 16'h0300, 8'h11, 8'h00, 1);
        settle(1'b0);
        host_u.set_protect(1'b0);
        wr(8'h01, 16'h0000, 8'h00, 8'h00, 1);
        settle(1'b0);
        status(8'h86);
        wr(8'h02, 16'h02ff, 8'h22, 8'h00, 1);
        settle(1'b1);
        host_u.set_protect(1'b1);
    endtask : t_protect
    // Write cut off mid-byte, then a status write aborted by the pin
    task automatic t_abort();
        cmd(8'h06);
        host_u.begin_frame();
        host_u.xfer(8'h02, rx);
        host_u.xfer(8'h00, rx);
        host_u.xfer(8'h10, rx);
        host_u.xfer(8'h77, rx);
        host_u.xfer(8'h55, rx, 3);
        host_u.end_frame();
        settle(1'b0);
        host_u.begin_frame();
        host_u.xfer(8'h01, rx);
        host_u.xfer(8'h00, rx);
        host_u.set_protect(1'b0);
        host_u.end_frame();
        settle(1'b0);
        host_u.set_protect(1'b1);
        status(8'h86);
    endtask : t_abort
    // ----------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------
    initial begin
        fails = 0;
        checks_done = 0;
        reset = 1'b1;
        repeat (3) @(negedge ref_clk);
        reset = 1'b0;
        repeat (4) @(negedge ref_clk);
        t_power();
        t_latch();
        t_page();
        t_protect();
        t_abort();
        give_verdict();
    end
    // Run needs about 6000 clocks; ten times that means a hang
    initial begin
        repeat (60000) @(posedge ref_clk);
        fails++;
        give_verdict();
    end
endmodule : test_spi_eeprom_command_logic
`default_nettype wire
